/* hdl/charger_config_register_bank.sv */
// Four configuration registers of a battery charger plus watchdog restart and fault.
// Assumes the serial engine gives single-cycle read and write strobes on this clock.
//
// Function
// R1 - Precharge code bits 7:4, 60 mA steps
// R2 - Precharge code above 1100 acts as 1100
// R3 - Termination code bits 3:0, 60 mA steps
// R4 - Charge voltage code bits 7:3, 32 mV
// R5 - Written voltage code above 11000 stored 11000
// R6 - Top-off time bits 2:1, off default
// R7 - Top-off 00 ends charge at termination
// R8 - Recharge threshold bit 0, default 100 mV
// R9 - Termination enable bit 7, default on
// R10 - Watchdog period bits 5:4, default 40 s
// R11 - Bit 3 enables both safety timers
// R12 - Bit 2 selects 5 or 10 hours
// R13 - Bit 1 selects thermal regulation limit
// R14 - Bit 0 selects cold band current scale
// R15 - Bit 6 reserved, resets to 0
// R16 - Overvoltage threshold bits 7:6, default 6.5 V
// R17 - Boost voltage bits 5:4, default 5.15 V
// R18 - Input voltage limit bits 3:0, default 0110
// R19 - Register reset restores all; watchdog first three
// R20 - Restart bit self-clears after restart
// R21 - Watchdog expiry sets fault status bit
// R22 - Reserved bit stores writes, no function
// R23 - Host restarts watchdog to keep settings
`timescale 1ns/1ps
module charger_config_register_bank #(
	parameter int TICK_CYCLES = charger_cfg_pkg::TICK_CYCLES
) (
	input  wire logic       clk_sys_i,
	input  wire logic       reset_n_i,
	input  wire logic [7:0] addr_i,
	input  wire logic       wr_en_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       rd_en_i,
	output logic      [7:0] rd_data_o,
	output logic            rd_valid_o,
	input  wire logic       reg_reset_i,
	input  wire logic       wd_restart_req_i,
	output logic            watchdog_restart_bit_o,
	output logic            watchdog_fault_o,
	output logic      [3:0] precharge_current_code_o,
	output logic      [3:0] termination_current_code_o,
	output logic      [4:0] charge_voltage_code_o,
	output logic      [1:0] extended_charge_time_o,
	output logic            extended_charge_en_o,
	output logic            recharge_threshold_select_o,
	output logic            termination_en_o,
	output logic      [1:0] watchdog_period_o,
	output logic            safety_timer_en_o,
	output logic            fast_charge_timer_length_o,
	output logic            thermal_regulation_limit_o,
	output logic            cold_band_current_scale_o,
	output logic      [1:0] input_overvoltage_threshold_o,
	output logic      [1:0] boost_output_voltage_o,
	output logic      [3:0] input_voltage_limit_o
);

	logic [7:0] prechg_term_q;
	logic [7:0] prechg_term_d;
	logic [7:0] volt_topoff_q;
	logic [7:0] volt_topoff_d;
	logic [7:0] term_timers_q;
	logic [7:0] term_timers_d;
	logic [7:0] input_boost_q;
	logic [7:0] input_boost_d;
	logic       restart_bit_q;
	logic       restart_bit_d;
	logic       fault_q;
	logic       fault_d;
	logic [3:0] prechg_eff_q;
	logic [3:0] prechg_eff_d;
	logic       topoff_en_q;
	logic       topoff_en_d;
	logic [7:0] rd_data_q;
	logic [7:0] rd_data_d;
	logic       rd_valid_q;
	logic       wd_expire;
	logic [4:0] volt_wr;

	// ==========================================================
	// Watchdog
	charger_watchdog #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_watchdog (
		.clk_sys_i     (clk_sys_i),
		.reset_n_i     (reset_n_i),
		.period_code_i (term_timers_q[charger_cfg_pkg::WD_MSB:charger_cfg_pkg::WD_LSB]), // R10
		.restart_i     (restart_bit_q), // R20
		.expire_o      (wd_expire)
	);

	// ==========================================================
	// Configuration registers
	always_comb begin
		prechg_term_d = prechg_term_q;
		volt_topoff_d = volt_topoff_q;
		term_timers_d = term_timers_q;
		input_boost_d = input_boost_q;
		volt_wr       = wr_data_i[charger_cfg_pkg::VOLT_MSB:charger_cfg_pkg::VOLT_LSB];
		if (wr_en_i) begin
			if (addr_i == charger_cfg_pkg::ADDR_PRECHG_TERM) begin
				prechg_term_d = wr_data_i; // R1 R3
			end else if (addr_i == charger_cfg_pkg::ADDR_VOLT_TOPOFF) begin
				volt_topoff_d = wr_data_i; // R4 R6 R8
				if (volt_wr > charger_cfg_pkg::VOLT_CODE_MAX) begin
					volt_topoff_d[charger_cfg_pkg::VOLT_MSB:charger_cfg_pkg::VOLT_LSB] =
						charger_cfg_pkg::VOLT_CODE_MAX; // R5
				end
			end else if (addr_i == charger_cfg_pkg::ADDR_TERM_TIMERS) begin
				// Reserved bit is kept as written and drives nothing
				term_timers_d = wr_data_i; // R9 R11 R12 R13 R14 R15 R22
			end else if (addr_i == charger_cfg_pkg::ADDR_INPUT_BOOST) begin
				input_boost_d = wr_data_i; // R16 R17 R18
			end
		end
		// Expiry beats a same-cycle write except to ADDR_INPUT_BOOST; a host that stops restarting loses settings
		if (wd_expire) begin
			prechg_term_d = charger_cfg_pkg::POR_PRECHG_TERM; // R19 R23
			volt_topoff_d = charger_cfg_pkg::POR_VOLT_TOPOFF; // R19
			term_timers_d = charger_cfg_pkg::POR_TERM_TIMERS; // R19
		end
		if (reg_reset_i) begin
			prechg_term_d = charger_cfg_pkg::POR_PRECHG_TERM; // R19
			volt_topoff_d = charger_cfg_pkg::POR_VOLT_TOPOFF; // R19
			term_timers_d = charger_cfg_pkg::POR_TERM_TIMERS; // R19
			input_boost_d = charger_cfg_pkg::POR_INPUT_BOOST; // R19
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prechg_term_q <= charger_cfg_pkg::POR_PRECHG_TERM;
			volt_topoff_q <= charger_cfg_pkg::POR_VOLT_TOPOFF;
			term_timers_q <= charger_cfg_pkg::POR_TERM_TIMERS;
			input_boost_q <= charger_cfg_pkg::POR_INPUT_BOOST;
		end else begin
			prechg_term_q <= prechg_term_d;
			volt_topoff_q <= volt_topoff_d;
			term_timers_q <= term_timers_d;
			input_boost_q <= input_boost_d;
		end
	end

	// ==========================================================
	// Restart bit, fault status, derived controls
	always_comb begin
		// Restart bit holds one cycle, long enough for the watchdog to take it
		restart_bit_d = wd_restart_req_i; // R20
		if (reg_reset_i) begin
			restart_bit_d = 1'b0;
		end
		fault_d = fault_q;
		if (restart_bit_q || reg_reset_i) begin
			fault_d = 1'b0;
		end
		// Set wins over clear
		if (wd_expire) begin
			fault_d = 1'b1; // R21
		end
		prechg_eff_d = prechg_term_d[charger_cfg_pkg::PRECHG_MSB:charger_cfg_pkg::PRECHG_LSB];
		if (prechg_eff_d > charger_cfg_pkg::PRECHG_CODE_MAX) begin
			prechg_eff_d = charger_cfg_pkg::PRECHG_CODE_MAX; // R2
		end
		topoff_en_d = (volt_topoff_d[charger_cfg_pkg::TOPOFF_MSB:charger_cfg_pkg::TOPOFF_LSB]
			!= charger_cfg_pkg::TOPOFF_OFF); // R7
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			restart_bit_q <= 1'b0;
			fault_q       <= 1'b0;
			prechg_eff_q  <= charger_cfg_pkg::POR_PRECHG_TERM[charger_cfg_pkg::PRECHG_MSB:charger_cfg_pkg::PRECHG_LSB];
			topoff_en_q   <= 1'b0;
		end else begin
			restart_bit_q <= restart_bit_d;
			fault_q       <= fault_d;
			prechg_eff_q  <= prechg_eff_d;
			topoff_en_q   <= topoff_en_d;
		end
	end

	// ==========================================================
	// Read port
	always_comb begin
		rd_data_d = rd_data_q;
		if (rd_en_i) begin
			if (addr_i == charger_cfg_pkg::ADDR_PRECHG_TERM) begin
				rd_data_d = prechg_term_q;
			end else if (addr_i == charger_cfg_pkg::ADDR_VOLT_TOPOFF) begin
				rd_data_d = volt_topoff_q;
			end else if (addr_i == charger_cfg_pkg::ADDR_TERM_TIMERS) begin
				rd_data_d = term_timers_q; // R22
			end else if (addr_i == charger_cfg_pkg::ADDR_INPUT_BOOST) begin
				rd_data_d = input_boost_q;
			end else begin
				rd_data_d = charger_cfg_pkg::READ_UNMAPPED;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_q  <= 8'h00;
			rd_valid_q <= 1'b0;
		end else begin
			rd_data_q  <= rd_data_d;
			rd_valid_q <= rd_en_i;
		end
	end

	// ==========================================================
	// Outputs, all from flops
	assign rd_data_o                     = rd_data_q;
	assign rd_valid_o                    = rd_valid_q;
	assign watchdog_restart_bit_o        = restart_bit_q;
	assign watchdog_fault_o              = fault_q;
	assign precharge_current_code_o      = prechg_eff_q;
	assign termination_current_code_o    = prechg_term_q[charger_cfg_pkg::TERM_CUR_MSB:charger_cfg_pkg::TERM_CUR_LSB];
	assign charge_voltage_code_o         = volt_topoff_q[charger_cfg_pkg::VOLT_MSB:charger_cfg_pkg::VOLT_LSB];
	assign extended_charge_time_o        = volt_topoff_q[charger_cfg_pkg::TOPOFF_MSB:charger_cfg_pkg::TOPOFF_LSB];
	assign extended_charge_en_o          = topoff_en_q;
	assign recharge_threshold_select_o   = volt_topoff_q[charger_cfg_pkg::RECHG_BIT];
	assign termination_en_o              = term_timers_q[charger_cfg_pkg::TERM_EN_BIT];
	assign watchdog_period_o             = term_timers_q[charger_cfg_pkg::WD_MSB:charger_cfg_pkg::WD_LSB];
	assign safety_timer_en_o             = term_timers_q[charger_cfg_pkg::TIMER_EN_BIT];
	assign fast_charge_timer_length_o    = term_timers_q[charger_cfg_pkg::TIMER_LEN_BIT];
	assign thermal_regulation_limit_o    = term_timers_q[charger_cfg_pkg::THERMAL_BIT];
	assign cold_band_current_scale_o     = term_timers_q[charger_cfg_pkg::COLD_BIT];
	assign input_overvoltage_threshold_o = input_boost_q[charger_cfg_pkg::OVERVOLT_MSB:charger_cfg_pkg::OVERVOLT_LSB];
	assign boost_output_voltage_o        = input_boost_q[charger_cfg_pkg::BOOST_MSB:charger_cfg_pkg::BOOST_LSB];
	assign input_voltage_limit_o         = input_boost_q[charger_cfg_pkg::VIN_MSB:charger_cfg_pkg::VIN_LSB];

	// ==========================================================
	// Checks
	a_precharge_clamp: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // R2
		prechg_term_q[7:4] > 4'hC |-> precharge_current_code_o == 4'hC)
		else $error("precharge code not clamped");

	a_precharge_pass: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // R1
		prechg_term_q[7:4] <= 4'hC |-> precharge_current_code_o == prechg_term_q[7:4])
		else $error("precharge code altered");

	a_voltage_clamp: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // R5
		wr_en_i && addr_i == 8'h04 && wr_data_i[7:3] > 5'h18 && !reg_reset_i && !wd_expire
		|=> charge_voltage_code_o == 5'h18)
		else $error("charge voltage not clamped on write");

	a_reg_reset_por: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // R19
		reg_reset_i |=> prechg_term_q == 8'h22 && volt_topoff_q == 8'h58
		&& term_timers_q == 8'h9F && input_boost_q == 8'h66)
		else $error("register reset did not restore values");

	a_wd_expire_por: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // R19
		wd_expire && !reg_reset_i |=> prechg_term_q == 8'h22 && volt_topoff_q == 8'h58
		&& term_timers_q == 8'h9F && input_boost_q == $past(input_boost_d))
		else $error("watchdog expiry restore wrong");

	a_fault_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // R21
		wd_expire |=> watchdog_fault_o ##1 (watchdog_fault_o || $past(restart_bit_q || reg_reset_i)))
		else $error("watchdog fault not set");

	a_restart_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // R20
		wd_restart_req_i && !reg_reset_i ##1 !wd_restart_req_i |-> watchdog_restart_bit_o ##1 !watchdog_restart_bit_o)
		else $error("restart bit did not self clear");

	a_topoff_flag: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // R7
		extended_charge_en_o == (extended_charge_time_o != 2'b00))
		else $error("top-off enable mismatch");

	a_reserved_store: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // R22
		wr_en_i && addr_i == 8'h05 && !reg_reset_i && !wd_expire
		|=> term_timers_q[6] == $past(wr_data_i[6]))
		else $error("reserved bit not stored");

	a_read_unmapped: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_en_i && (addr_i < 8'h03 || addr_i > 8'h06) |=> rd_valid_o && rd_data_o == 8'h00)
		else $error("unmapped read not zero");

endmodule : charger_config_register_bank

/* include/charger_cfg_pkg.sv */
// Constants for the charger configuration register bank and its watchdog.
// Assumes one 250 MHz system clock and a serial engine that issues byte reads and writes.
package charger_cfg_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [7:0] ADDR_PRECHG_TERM  = 8'h03;
	localparam logic [7:0] ADDR_VOLT_TOPOFF  = 8'h04;
	localparam logic [7:0] ADDR_TERM_TIMERS  = 8'h05;
	localparam logic [7:0] ADDR_INPUT_BOOST  = 8'h06;

	// ==========================================================
	// Power-on values
	localparam logic [7:0] POR_PRECHG_TERM   = 8'h22;
	localparam logic [7:0] POR_VOLT_TOPOFF   = 8'h58;
	localparam logic [7:0] POR_TERM_TIMERS   = 8'h9F;
	localparam logic [7:0] POR_INPUT_BOOST   = 8'h66;
	localparam logic [7:0] READ_UNMAPPED     = 8'h00;

	// ==========================================================
	// Field positions
	localparam int PRECHG_MSB     = 7;
	localparam int PRECHG_LSB     = 4;
	localparam int TERM_CUR_MSB   = 3;
	localparam int TERM_CUR_LSB   = 0;
	localparam int VOLT_MSB       = 7;
	localparam int VOLT_LSB       = 3;
	localparam int TOPOFF_MSB     = 2;
	localparam int TOPOFF_LSB     = 1;
	localparam int RECHG_BIT      = 0;
	localparam int TERM_EN_BIT    = 7;
	localparam int RESERVED_BIT   = 6;
	localparam int WD_MSB         = 5;
	localparam int WD_LSB         = 4;
	localparam int TIMER_EN_BIT   = 3;
	localparam int TIMER_LEN_BIT  = 2;
	localparam int THERMAL_BIT    = 1;
	localparam int COLD_BIT       = 0;
	localparam int OVERVOLT_MSB   = 7;
	localparam int OVERVOLT_LSB   = 6;
	localparam int BOOST_MSB      = 5;
	localparam int BOOST_LSB      = 4;
	localparam int VIN_MSB        = 3;
	localparam int VIN_LSB        = 0;

	// ==========================================================
	// Clamps and codes
	localparam logic [3:0] PRECHG_CODE_MAX  = 4'hC;
	localparam logic [4:0] VOLT_CODE_MAX    = 5'h18;
	localparam logic [1:0] TOPOFF_OFF       = 2'h0;
	localparam logic [1:0] WD_OFF           = 2'h0;
	localparam logic [1:0] WD_40S           = 2'h1;
	localparam logic [1:0] WD_80S           = 2'h2;
	localparam logic [7:0] WD_40S_COUNT     = 8'h28;
	localparam logic [7:0] WD_80S_COUNT     = 8'h50;
	localparam logic [7:0] WD_160S_COUNT    = 8'hA0;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_PS  = 4000;
	localparam longint TICK_TIME_S = 1;
	localparam int TICK_CYCLES    = int'((TICK_TIME_S * 64'd1_000_000_000_000) / CLK_PERIOD_PS);

endpackage : charger_cfg_pkg

/* hdl/charger_watchdog.sv */
// Watchdog for the charger register bank: one-second divider and period counter.
// Assumes restart and period come from the register bank on the same clock.
`timescale 1ns/1ps
module charger_watchdog #(
	parameter int TICK_CYCLES = charger_cfg_pkg::TICK_CYCLES
) (
	input  wire logic       clk_sys_i,
	input  wire logic       reset_n_i,
	input  wire logic [1:0] period_code_i,
	input  wire logic       restart_i,
	output logic            expire_o
);

	logic [27:0] tick_cnt_q;
	logic [27:0] tick_cnt_d;
	logic [7:0]  sec_cnt_q;
	logic [7:0]  sec_cnt_d;
	logic        expire_q;
	logic        expire_d;
	logic [7:0]  limit;
	logic        tick;

	// ==========================================================
	// Period select and second counter
	always_comb begin
		limit = charger_cfg_pkg::WD_160S_COUNT;
		if (period_code_i == charger_cfg_pkg::WD_40S) begin
			limit = charger_cfg_pkg::WD_40S_COUNT;
		end else if (period_code_i == charger_cfg_pkg::WD_80S) begin
			limit = charger_cfg_pkg::WD_80S_COUNT;
		end
		tick       = (tick_cnt_q == 28'(TICK_CYCLES - 1));
		tick_cnt_d = tick ? 28'h0000000 : tick_cnt_q + 28'h0000001;
		sec_cnt_d  = sec_cnt_q;
		expire_d   = 1'b0;
		if (tick) begin
			sec_cnt_d = sec_cnt_q + 8'h01;
		end
		// Disabled or restarted: start a fresh full period
		if (restart_i || period_code_i == charger_cfg_pkg::WD_OFF) begin
			tick_cnt_d = 28'h0000000;
			sec_cnt_d  = 8'h00;
		end else if (tick && sec_cnt_d >= limit) begin
			expire_d   = 1'b1;
			sec_cnt_d  = 8'h00;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tick_cnt_q <= 28'h0000000;
			sec_cnt_q  <= 8'h00;
			expire_q   <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			sec_cnt_q  <= sec_cnt_d;
			expire_q   <= expire_d;
		end
	end

	assign expire_o = expire_q;

endmodule : charger_watchdog

/* sim/charger_host_model.sv */
// Host model: issues byte reads, writes and watchdog restarts to the register bank.
// Assumes the bank samples strobes on the rising edge of the shared system clock.
`timescale 1ns/1ps
module charger_host_model (
	input  wire logic       clk_sys_i,
	output logic      [7:0] addr_o,
	output logic            wr_en_o,
	output logic      [7:0] wr_data_o,
	output logic            rd_en_o,
	output logic            wd_restart_req_o,
	input  wire logic [7:0] rd_data_i,
	input  wire logic       rd_valid_i
);
	// ==========================================================
	// Idle state
	initial begin
		addr_o           = 8'h00;
		wr_en_o          = 1'b0;
		wr_data_o        = 8'h00;
		rd_en_o          = 1'b0;
		wd_restart_req_o = 1'b0;
	end

	// ==========================================================
	// Transfers
	// Released lines flip so a stale address is never read as valid
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_o    <= a;
		wr_data_o <= d;
		wr_en_o   <= 1'b1;
		@(posedge clk_sys_i);
		wr_en_o   <= 1'b0;
		addr_o    <= ~a;
		wr_data_o <= ~d;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_sys_i);
		addr_o  <= a;
		rd_en_o <= 1'b1;
		@(posedge clk_sys_i);
		rd_en_o <= 1'b0;
		addr_o  <= ~a;
		@(negedge clk_sys_i);
		d = rd_data_i;
		v = rd_valid_i;
	endtask : read_reg

	// Host pulses the restart request for one cycle to keep its settings
	task automatic restart_wd;
		@(posedge clk_sys_i);
		wd_restart_req_o <= 1'b1;
		@(posedge clk_sys_i);
		wd_restart_req_o <= 1'b0;
	endtask : restart_wd
endmodule : charger_host_model

/* sim/tb_top.sv */
// Testbench for the charger configuration register bank.
// Assumes a shortened watchdog tick of 10 cycles, so 40 s is 400 cycles.
`timescale 1ns/1ps
module tb_top;
	localparam int         TICK = 10;
	localparam logic [7:0] A3   = charger_cfg_pkg::ADDR_PRECHG_TERM;
	localparam logic [7:0] A4   = charger_cfg_pkg::ADDR_VOLT_TOPOFF;
	localparam logic [7:0] A5   = charger_cfg_pkg::ADDR_TERM_TIMERS;
	localparam logic [7:0] A6   = charger_cfg_pkg::ADDR_INPUT_BOOST;

	logic clk_sys_i, reset_n_i, wr_en, rd_en, rd_valid, reg_reset_i, wd_req, wd_bit, wd_fault;
	logic [7:0] addr, wr_data, rd_data;
	logic [3:0] prechg, term_cur, vin;
	logic [4:0] volt;
	logic [1:0] ext_time, wd_period, ov_thr, boost;
	logic ext_en, rechg, term_en, tmr_en, tmr_len, thermal, cold;
	int bad_count = 0;
	int n_compared = 0;

	// ==========================================================
	// Clock, reset, instances
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	charger_config_register_bank #(.TICK_CYCLES(TICK)) dut_u (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr), .wr_en_i(wr_en), .wr_data_i(wr_data),
		.rd_en_i(rd_en), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .reg_reset_i(reg_reset_i),
		.wd_restart_req_i(wd_req), .watchdog_restart_bit_o(wd_bit), .watchdog_fault_o(wd_fault),
		.precharge_current_code_o(prechg), .termination_current_code_o(term_cur),
		.charge_voltage_code_o(volt), .extended_charge_time_o(ext_time), .extended_charge_en_o(ext_en),
		.recharge_threshold_select_o(rechg), .termination_en_o(term_en), .watchdog_period_o(wd_period),
		.safety_timer_en_o(tmr_en), .fast_charge_timer_length_o(tmr_len),
		.thermal_regulation_limit_o(thermal), .cold_band_current_scale_o(cold),
		.input_overvoltage_threshold_o(ov_thr), .boost_output_voltage_o(boost), .input_voltage_limit_o(vin)
	);

	charger_host_model host_u (
		.clk_sys_i(clk_sys_i), .addr_o(addr), .wr_en_o(wr_en), .wr_data_o(wr_data), .rd_en_o(rd_en),
		.wd_restart_req_o(wd_req), .rd_data_i(rd_data), .rd_valid_i(rd_valid)
	);

	// ==========================================================
	// Checking helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		host_u.read_reg(a, d, v);
		check(8'(v), 8'h01);
		check(d, exp);
	endtask : read_check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.write_reg(a, d);
		@(negedge clk_sys_i);
	endtask : wr

	task automatic por_all(input logic [7:0] r6);
		read_check(A3, {4'h2, 4'h2});
		read_check(A4, {5'h0B, 2'h0, 1'b0});
		read_check(A5, 8'h9F);
		read_check(A6, r6);
	endtask : por_all

	task automatic complete_run;
		$display("compared %0d, mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	// ==========================================================
	// Scenarios
	task automatic test_por;
		por_all({2'h1, 2'h2, 4'h6});
		check(8'(prechg), 8'h02);
		check(8'(ext_en), 8'h00);
		check({6'h0, wd_bit, wd_fault}, 8'h00);
		$display("test por done");
	endtask : test_por

	task automatic test_precharge;
		host_u.restart_wd();
		for (int c = 10; c < 16; c++) begin
			wr(A3, {4'(c), 4'(c - 5)});
			check(8'(prechg), (c > 12) ? 8'h0C : 8'(c));
			check(8'(term_cur), 8'(c - 5));
			read_check(A3, {4'(c), 4'(c - 5)});
		end
		$display("test precharge done");
	endtask : test_precharge

	task automatic test_voltage;
		host_u.restart_wd();
		wr(A4, 8'hFF);
		check(8'(volt), 8'h18);
		read_check(A4, 8'hC7);
		wr(A4, {5'h19, 3'h0});
		read_check(A4, {5'h18, 3'h0});
		wr(A4, {5'h0F, 3'h1});
		check(8'(volt), 8'h0F);
		check(8'(rechg), 8'h01);
		for (int t = 0; t < 4; t++) begin
			wr(A4, {5'h0B, 2'(t), 1'b0});
			check(8'(ext_time), 8'(t));
			check(8'(ext_en), (t != 0) ? 8'h01 : 8'h00);
		end
		$display("test voltage done");
	endtask : test_voltage

	task automatic test_timers;
		logic [7:0] vals [3] = '{8'h62, 8'h1D, 8'hE0};
		host_u.restart_wd();
		foreach (vals[i]) begin
			wr(A5, vals[i]);
			check({term_en, 1'b0, wd_period, tmr_en, tmr_len, thermal, cold}, vals[i] & 8'hBF);
			read_check(A5, vals[i]);
		end
		$display("test timers done");
	endtask : test_timers

	task automatic test_input;
		host_u.restart_wd();
		wr(A6, 8'hD9);
		check({ov_thr, boost, vin}, 8'hD9);
		wr(A6, 8'h24);
		check({ov_thr, boost, vin}, 8'h24);
		wr(8'h07, 8'hA5);
		read_check(8'h07, 8'h00);
		read_check(8'h02, 8'h00);
		read_check(A6, 8'h24);
		$display("test input done");
	endtask : test_input

	task automatic test_reg_reset;
		@(posedge clk_sys_i);
		reg_reset_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_reset_i <= 1'b0;
		por_all({2'h1, 2'h2, 4'h6});
		$display("test register reset done");
	endtask : test_reg_reset

	task automatic wd_period_check(input logic [7:0] r5, input int secs);
		int n;
		wr(A5, r5);
		host_u.restart_wd();
		repeat (2) @(negedge clk_sys_i);
		check(8'(wd_fault), 8'h00);
		n = 2;
		// Counted from the restart edge; expiry shows a couple of cycles after the period
		while (wd_fault !== 1'b1 && n < secs * TICK + 50) begin
			@(negedge clk_sys_i);
			n++;
		end
		check(8'(n >= secs * TICK - 10 && n <= secs * TICK + 10), 8'h01);
		check(8'(wd_fault), 8'h01);
		if (n >= secs * TICK + 50) complete_run();
	endtask : wd_period_check

	task automatic test_watchdog;
		int n;
		host_u.restart_wd();
		@(negedge clk_sys_i);
		check(8'(wd_bit), 8'h01);
		@(negedge clk_sys_i);
		check(8'(wd_bit), 8'h00);
		wr(A3, 8'h55);
		wr(A4, 8'h13);
		wr(A5, 8'h50);
		wr(A6, 8'h15);
		n = 0;
		// Bound covers 40 s plus 20 ticks of slack
		while (wd_fault !== 1'b1 && n < 600) begin
			@(negedge clk_sys_i);
			n++;
		end
		check(8'(wd_fault), 8'h01);
		if (n >= 600) complete_run();
		por_all(8'h15);
		host_u.restart_wd();
		repeat (2) @(negedge clk_sys_i);
		check(8'(wd_fault), 8'h00);
		wr(A5, 8'h8F);
		host_u.restart_wd();
		repeat (900) @(negedge clk_sys_i);
		check(8'(wd_fault), 8'h00);
		read_check(A5, 8'h8F);
		wd_period_check(8'h60, 80);
		wd_period_check(8'hB0, 160);
		$display("test watchdog done");
	endtask : test_watchdog

	// ==========================================================
	// Main sequence
	initial begin
		reset_n_i   <= 1'b0;
		reg_reset_i <= 1'b0;
		repeat (10) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		test_por();
		test_precharge();
		test_voltage();
		test_timers();
		test_input();
		test_reg_reset();
		test_watchdog();
		complete_run();
	end
endmodule : tb_top
